// File: src/dtm_pkg.sv
package dtm_pkg;
    // Read addresses
    localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] RD_REMOTE_TEMP = 8'h01;
    localparam logic [7:0] RD_STATUS = 8'h02;
    localparam logic [7:0] RD_CONFIG = 8'h03;
    localparam logic [7:0] RD_CONV_RATE = 8'h04;
    localparam logic [7:0] RD_LOCAL_HIGH = 8'h05;
    localparam logic [7:0] RD_LOCAL_LOW = 8'h06;
    localparam logic [7:0] RD_REMOTE_HIGH = 8'h07;
    localparam logic [7:0] RD_REMOTE_LOW = 8'h08;
    localparam logic [7:0] RD_MAKER_ID = 8'hfe;
    localparam logic [7:0] RD_DIE_REV = 8'hff;
    // Write addresses
    localparam logic [7:0] WR_CONFIG = 8'h09;
    localparam logic [7:0] WR_CONV_RATE = 8'h0a;
    localparam logic [7:0] WR_LOCAL_HIGH = 8'h0b;
    localparam logic [7:0] WR_LOCAL_LOW = 8'h0c;
    localparam logic [7:0] WR_REMOTE_HIGH = 8'h0d;
    localparam logic [7:0] WR_REMOTE_LOW = 8'h0e;
    localparam logic [7:0] WR_ONE_SHOT = 8'h0f;
    // Reset values and result floor
    localparam logic [7:0] TEMP_RESET = 8'h80;
    localparam logic [7:0] HIGH_RESET = 8'h7f;
    localparam logic [7:0] LOW_RESET = 8'hc9;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] RATE_RESET = 8'h02;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] TEMP_FLOOR = 8'hbf;
    // Arbitrary identity values
    localparam logic [7:0] MAKER_ID_DEFAULT = 8'h5a;
    localparam logic [7:0] DIE_REV_DEFAULT = 8'h01;
    // Field positions
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_STOP_BIT = 6;
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_LOVER_BIT = 6;
    localparam int ST_LUNDER_BIT = 5;
    localparam int ST_ROVER_BIT = 4;
    localparam int ST_RUNDER_BIT = 3;
    localparam int ST_OPEN_BIT = 2;
    // Samples per averaged result
    localparam int AVG_COUNT = 16;
    localparam int AVG_SHIFT = 4;
    typedef enum logic [1:0] {BUS_IDLE, BUS_PTR, BUS_DATA} dtm_bus_t;
endpackage

// File: src/dtm_regs.sv
`timescale 1ns/1ns
// Functional notes
// - Each result averages sixteen raw samples
// - Results are 8-bit two's complement degrees
// - Stored results clamp to -65 minimum
// - Store results then compare against limits
// - Separate read and write addresses
// - First write byte loads the pointer
// - Value registers are converter-written only
// - Status bit 7 shows conversion busy
// - Status bits 6..3 hold limit trips
// - Status bit 2 flags open remote sensor
// - Any flag sets alert latch, alert low
// - Status read clears flags no longer active
// - Flag stays while condition persists
// - Flags stay until status read or reset
// - Value registers reset to 0x80
// - High limits 0x7F, low limits 0xC9
// - Limit, config, rate read/write addresses
// - Write to 0x0F runs until one remote result lands
// - Strict greater / strict less comparisons
// - Config mask, stop bit, standby pin
// - Alert latch released only by servicing
module dtm_regs
    import dtm_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = MAKER_ID_DEFAULT,
    parameter logic [7:0] DIE_REV = DIE_REV_DEFAULT
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic bus_start,
    input wire logic bus_wr_valid,
    input wire logic [7:0] bus_wr_data,
    input wire logic bus_rd_req,
    input wire logic alert_service,
    input wire logic adc_valid,
    input wire logic adc_channel,
    input wire logic [7:0] adc_sample,
    input wire logic adc_busy,
    input wire logic remote_open,
    input wire logic standby_pin_n,
    output logic [7:0] bus_rd_data_q,
    output logic convert_run_q,
    output logic [2:0] conv_rate_q,
    output logic alert_n_q
);
    import dtm_pkg::*;

    dtm_bus_t bus_state_q;
    logic [7:0] ptr_q;
    logic [7:0] local_temp_q;
    logic [7:0] remote_temp_q;
    logic [7:0] config_q;
    logic [7:0] rate_q;
    logic [7:0] limit_q [4];
    logic [4:0] flags_q;
    logic alert_latch_q;
    logic one_shot_q;
    logic [11:0] acc_q [2];
    logic [3:0] cnt_q [2];
    logic [4:0] cond;
    logic [7:0] status_view;
    logic [7:0] rd_mux;
    logic standby;
    logic wr_data;
    logic [7:0] avg [2];
    logic avg_done [2];

    assign standby = config_q[CFG_STOP_BIT] | ~standby_pin_n;
    assign wr_data = bus_wr_valid & (bus_state_q == BUS_DATA);

    // Bus byte sequencing: first byte after start is always the pointer
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            bus_state_q <= BUS_IDLE;
        else if (bus_start)
            bus_state_q <= BUS_PTR;
        else if (bus_wr_valid && bus_state_q == BUS_PTR)
            bus_state_q <= BUS_DATA;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            ptr_q <= PTR_RESET;
        else if (bus_wr_valid && bus_state_q == BUS_PTR)
            ptr_q <= bus_wr_data;
    end

    // Config and rate; only low three rate bits carry meaning
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            config_q <= CONFIG_RESET;
            rate_q <= RATE_RESET;
        end
        else if (wr_data)
        begin
            if (ptr_q == WR_CONFIG)
                config_q <= bus_wr_data;
            if (ptr_q == WR_CONV_RATE)
                rate_q <= bus_wr_data;
        end
    end

    // Limit registers written at their own write addresses
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_lim
            always_ff @(posedge core_clk or negedge rstn)
            begin
                if (!rstn)
                    limit_q[i] <= (i[0] == 1'b0) ? HIGH_RESET : LOW_RESET;
                else if (wr_data && ptr_q == WR_LOCAL_HIGH + 8'(i))
                    limit_q[i] <= bus_wr_data;
            end
        end
    endgenerate

    // One-shot request, held until the converter has produced a remote result
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            one_shot_q <= 1'b0;
        else if (wr_data && ptr_q == WR_ONE_SHOT)
            one_shot_q <= 1'b1;
        else if (avg_done[1])
            one_shot_q <= 1'b0;
    end

    chk_oneshot_ends: assert property (@(posedge core_clk) disable iff (!rstn)
        (avg_done[1] && !(wr_data && ptr_q == WR_ONE_SHOT)) |=> !one_shot_q)
        else $error("one-shot request outlived its result");

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            convert_run_q <= 1'b0;
        else
            convert_run_q <= ~standby | one_shot_q;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            conv_rate_q <= 3'h0;
        else
            conv_rate_q <= rate_q[2:0];
    end

    // Averaging filter per channel; floor at -65 degrees
    // A stop keeps the partial sum, so the next run first finishes that average
    generate
        for (genvar c = 0; c < 2; c++)
        begin : g_avg
            logic [11:0] sum;
            logic [7:0] mean;
            assign sum = acc_q[c] + {{4{adc_sample[7]}}, adc_sample};
            assign mean = sum[AVG_SHIFT +: 8];
            assign avg_done[c] = adc_valid && adc_channel == c[0] && cnt_q[c] == 4'(AVG_COUNT - 1);
            assign avg[c] = ($signed(mean) < $signed(TEMP_FLOOR)) ? TEMP_FLOOR : mean;
            always_ff @(posedge core_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    acc_q[c] <= 12'h000;
                    cnt_q[c] <= 4'h0;
                end
                else if (adc_valid && adc_channel == c[0] && convert_run_q)
                begin
                    acc_q[c] <= avg_done[c] ? 12'h000 : sum;
                    cnt_q[c] <= cnt_q[c] + 4'h1;
                end
            end
        end
    endgenerate

    // Value registers only take converter results
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            local_temp_q <= TEMP_RESET;
            remote_temp_q <= TEMP_RESET;
        end
        else if (convert_run_q)
        begin
            if (avg_done[0])
                local_temp_q <= avg[0];
            if (avg_done[1])
                remote_temp_q <= avg[1];
        end
    end

    // Live comparisons against stored values, so flags track the registers
    assign cond[4] = $signed(local_temp_q) > $signed(limit_q[0]);
    assign cond[3] = $signed(local_temp_q) < $signed(limit_q[1]);
    assign cond[2] = $signed(remote_temp_q) > $signed(limit_q[2]);
    assign cond[1] = $signed(remote_temp_q) < $signed(limit_q[3]);
    assign cond[0] = remote_open;

    // Sticky flags: a live condition always wins over the read clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            flags_q <= 5'h00;
        else if (bus_rd_req && ptr_q == RD_STATUS)
            flags_q <= cond;
        else
            flags_q <= flags_q | cond;
    end

    chk_read_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus_rd_req && ptr_q == RD_STATUS && !cond[0]) |=> !flags_q[0])
        else $error("open flag survived status read");

    // Alert latch, released by servicing only once flags are clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            alert_latch_q <= 1'b0;
        else if (|flags_q)
            alert_latch_q <= 1'b1;
        else if (alert_service)
            alert_latch_q <= 1'b0;
    end

    chk_latch_release: assert property (@(posedge core_clk) disable iff (!rstn)
        (alert_service && flags_q == 5'h00) |=> !alert_latch_q)
        else $error("serviced alert latch not released");

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            alert_n_q <= 1'b1;
        else
            alert_n_q <= ~(alert_latch_q & ~config_q[CFG_MASK_BIT]);
    end

    assign status_view = {adc_busy & convert_run_q, flags_q, 2'b00};

    chk_busy_view: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus_rd_req && ptr_q == RD_STATUS) |=> bus_rd_data_q[ST_BUSY_BIT] == ($past(adc_busy) & $past(convert_run_q)))
        else $error("busy bit wrong in status read");

    // Read mux; write-only and unmapped addresses read zero
    always_comb
    begin
        case (ptr_q)
            RD_LOCAL_TEMP: rd_mux = local_temp_q;
            RD_REMOTE_TEMP: rd_mux = remote_temp_q;
            RD_STATUS: rd_mux = status_view;
            RD_CONFIG: rd_mux = config_q;
            RD_CONV_RATE: rd_mux = rate_q;
            RD_LOCAL_HIGH: rd_mux = limit_q[0];
            RD_LOCAL_LOW: rd_mux = limit_q[1];
            RD_REMOTE_HIGH: rd_mux = limit_q[2];
            RD_REMOTE_LOW: rd_mux = limit_q[3];
            RD_MAKER_ID: rd_mux = MAKER_ID;
            RD_DIE_REV: rd_mux = DIE_REV;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            bus_rd_data_q <= 8'h00;
        else if (bus_rd_req)
            bus_rd_data_q <= rd_mux;
    end

    // Guards on stored values, pointer, flags and alert; mask must stay clear two cycles for the alert
    chk_flag_holds: assert property (@(posedge core_clk) disable iff (!rstn)
        cond[4] |=> flags_q[4])
        else $error("local over flag cleared while active");
    chk_alert_sets: assert property (@(posedge core_clk) disable iff (!rstn)
        (|flags_q && !config_q[CFG_MASK_BIT]) ##1 !config_q[CFG_MASK_BIT] |=> !alert_n_q)
        else $error("alert not asserted");
    chk_value_floor: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(local_temp_q) |-> $signed(local_temp_q) >= $signed(TEMP_FLOOR))
        else $error("local value below floor");
    chk_ptr_load: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus_wr_valid && bus_state_q == BUS_PTR) |=> ptr_q == $past(bus_wr_data))
        else $error("pointer not loaded");
    chk_status_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
        (flags_q[0] && !(bus_rd_req && ptr_q == RD_STATUS)) |=> flags_q[0])
        else $error("open flag dropped without read");
    chk_latch_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        (alert_latch_q && !alert_service) |=> alert_latch_q)
        else $error("alert latch released early");
    chk_mask_alert: assert property (@(posedge core_clk) disable iff (!rstn)
        config_q[CFG_MASK_BIT] |=> alert_n_q)
        else $error("masked alert driven");
    chk_read_unmapped: assert property (@(posedge core_clk) disable iff (!rstn)
        (bus_rd_req && ptr_q >= WR_CONFIG && ptr_q < RD_MAKER_ID) |=> bus_rd_data_q == 8'h00)
        else $error("unmapped read not zero");
    chk_hold_standby: assert property (@(posedge core_clk) disable iff (!rstn)
        !convert_run_q |=> $stable(remote_temp_q))
        else $error("value changed in standby");
endmodule

// File: dv/dtm_host_model.sv
`timescale 1ns/1ns
// Bus host: one byte per cycle, every change 1 ns after a rising edge
module dtm_host_model
(
    input wire logic core_clk,
    output logic bus_start,
    output logic bus_wr_valid,
    output logic [7:0] bus_wr_data,
    output logic bus_rd_req,
    output logic alert_service,
    input wire logic [7:0] bus_rd_data_q
);
    // Idle data shows the inverse of the last byte, so a stale byte never matches
    initial
    begin
        {bus_start, bus_wr_valid, bus_rd_req, alert_service} = 4'h0;
        bus_wr_data = 8'h00;
    end
    // Start, then the pointer byte; valid is left high for the caller
    task automatic send_ptr(input logic [7:0] ptr);
        @(posedge core_clk) #1 bus_start = 1'b1;
        @(posedge core_clk) #1 bus_start = 1'b0;
        bus_wr_valid = 1'b1;
        bus_wr_data = ptr;
    endtask
    // Reserved space above the one-shot address is never written
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        if (addr <= 8'h0f)
        begin
            send_ptr(addr);
            @(posedge core_clk) #1 bus_wr_data = data;
            @(posedge core_clk) #1 bus_wr_valid = 1'b0;
            bus_wr_data = ~data;
        end
    endtask
    // Read data is registered, so it is taken one cycle after the request
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        send_ptr(addr);
        @(posedge core_clk) #1 bus_wr_valid = 1'b0;
        bus_wr_data = ~addr;
        bus_rd_req = 1'b1;
        @(posedge core_clk) #1 bus_rd_req = 1'b0;
        data = bus_rd_data_q;
    endtask
    task automatic service_alert();
        @(posedge core_clk) #1 alert_service = 1'b1;
        @(posedge core_clk) #1 alert_service = 1'b0;
    endtask
endmodule

// File: dv/dual_temp_monitor_regs_tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); end end
module dual_temp_monitor_regs_tb_top;
    import dtm_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic bus_start, bus_wr_valid, bus_rd_req, alert_service, convert_run_q, alert_n_q;
    logic [7:0] bus_wr_data, bus_rd_data_q, rv;
    logic adc_valid = 1'b0, adc_channel = 1'b0, adc_busy = 1'b0, remote_open = 1'b0, standby_pin_n = 1'b1;
    logic [7:0] adc_sample = 8'h00;
    logic [2:0] conv_rate_q;
    int bad_count = 0, checks_done = 0, cycles = 0;
    // Clock, and a cycle ceiling that cuts a hung run short
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end
    dtm_regs i_dut (.core_clk(core_clk), .rstn(rstn), .bus_start(bus_start), .bus_wr_valid(bus_wr_valid),
        .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req), .alert_service(alert_service),
        .adc_valid(adc_valid), .adc_channel(adc_channel), .adc_sample(adc_sample), .adc_busy(adc_busy),
        .remote_open(remote_open), .standby_pin_n(standby_pin_n), .bus_rd_data_q(bus_rd_data_q),
        .convert_run_q(convert_run_q), .conv_rate_q(conv_rate_q), .alert_n_q(alert_n_q));
    dtm_host_model i_host (.core_clk(core_clk), .bus_start(bus_start), .bus_wr_valid(bus_wr_valid),
        .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req), .alert_service(alert_service),
        .bus_rd_data_q(bus_rd_data_q));
    task automatic stop_test();
        $display("checks_done %0d bad_count %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Land just past an edge so the sample never races the design
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        i_host.read_reg(addr, rv);
        `CHK(rv, exp)
    endtask
    // Sixteen samples alternating a and b, one per cycle
    task automatic feed(input logic ch, input logic [7:0] a, input logic [7:0] b);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge core_clk) #1 adc_valid = 1'b1;
            adc_channel = ch;
            adc_sample = i[0] ? b : a;
        end
        @(posedge core_clk) #1 adc_valid = 1'b0;
        adc_sample = ~adc_sample;
        wait_cyc(3);
    endtask
    // Values of -128 sit under both low limits right after reset
    task automatic t_reset();
        rd_chk(RD_LOCAL_TEMP, TEMP_RESET);
        rd_chk(RD_REMOTE_TEMP, TEMP_RESET);
        rd_chk(RD_CONFIG, CONFIG_RESET);
        rd_chk(RD_CONV_RATE, RATE_RESET);
        rd_chk(RD_LOCAL_HIGH, HIGH_RESET);
        rd_chk(RD_LOCAL_LOW, LOW_RESET);
        rd_chk(RD_REMOTE_HIGH, HIGH_RESET);
        rd_chk(RD_REMOTE_LOW, LOW_RESET);
        rd_chk(WR_LOCAL_HIGH, 8'h00);
        rd_chk(8'h10, 8'h00);
        rd_chk(RD_STATUS, 8'h28);
        `CHK(alert_n_q, 1'b0);
        `CHK(convert_run_q, 1'b1);
    endtask
    task automatic t_average();
        feed(1'b0, 8'h14, 8'h15);
        feed(1'b1, 8'h9c, 8'h9c);
        rd_chk(RD_LOCAL_TEMP, 8'h14);
        rd_chk(RD_REMOTE_TEMP, TEMP_FLOOR);
        rd_chk(RD_STATUS, 8'h28);
        rd_chk(RD_STATUS, 8'h08);
        i_host.write_reg(WR_REMOTE_LOW, 8'h80);
        rd_chk(RD_STATUS, 8'h08);
        rd_chk(RD_STATUS, 8'h00);
        `CHK(alert_n_q, 1'b0);
        i_host.service_alert();
        wait_cyc(3);
        `CHK(alert_n_q, 1'b1);
    endtask
    // Equal value never trips, one step beyond does
    task automatic t_limits();
        logic [7:0] wa[4] = '{WR_LOCAL_HIGH, WR_LOCAL_LOW, WR_REMOTE_HIGH, WR_REMOTE_LOW};
        logic [7:0] eq[4] = '{8'h14, 8'h14, 8'hbf, 8'hbf};
        logic [7:0] tr[4] = '{8'h13, 8'h15, 8'hbe, 8'hc0};
        logic [7:0] rs[4] = '{8'h7f, 8'hc9, 8'h7f, 8'h80};
        for (int k = 0; k < 4; k++)
        begin
            i_host.write_reg(wa[k], eq[k]);
            rd_chk(RD_STATUS, 8'h00);
            i_host.write_reg(wa[k], tr[k]);
            rd_chk(wa[k] - 8'h06, tr[k]);
            rd_chk(RD_STATUS, 8'h40 >> k);
            i_host.write_reg(wa[k], rs[k]);
            rd_chk(RD_STATUS, 8'h40 >> k);
            rd_chk(RD_STATUS, 8'h00);
        end
        adc_busy = 1'b1;
        rd_chk(RD_STATUS, 8'h80);
        adc_busy = 1'b0;
    endtask
    task automatic t_open();
        remote_open = 1'b1;
        rd_chk(RD_STATUS, 8'h04);
        rd_chk(RD_STATUS, 8'h04);
        remote_open = 1'b0;
        rd_chk(RD_STATUS, 8'h04);
        rd_chk(RD_STATUS, 8'h00);
        i_host.service_alert();
        i_host.write_reg(WR_CONFIG, 8'h80);
        rd_chk(RD_CONFIG, 8'h80);
        remote_open = 1'b1;
        wait_cyc(4);
        `CHK(alert_n_q, 1'b1);
        remote_open = 1'b0;
        rd_chk(RD_STATUS, 8'h04);
        rd_chk(RD_STATUS, 8'h00);
        i_host.service_alert();
        i_host.write_reg(WR_CONFIG, 8'h00);
        wait_cyc(4);
        `CHK(alert_n_q, 1'b1);
    endtask
    // Stopped converter ignores samples; one-shot runs until a remote result lands
    task automatic t_stop();
        i_host.write_reg(WR_CONFIG, 8'h40);
        wait_cyc(2);
        `CHK(convert_run_q, 1'b0);
        feed(1'b0, 8'h30, 8'h30);
        rd_chk(RD_LOCAL_TEMP, 8'h14);
        i_host.write_reg(WR_ONE_SHOT, 8'h55);
        wait_cyc(2);
        `CHK(convert_run_q, 1'b1);
        feed(1'b1, 8'h20, 8'h20);
        rd_chk(RD_REMOTE_TEMP, 8'h20);
        `CHK(convert_run_q, 1'b0);
        rd_chk(WR_ONE_SHOT, 8'h00);
        i_host.write_reg(WR_CONFIG, 8'h00);
        standby_pin_n = 1'b0;
        wait_cyc(3);
        `CHK(convert_run_q, 1'b0);
        standby_pin_n = 1'b1;
    endtask
    task automatic t_protect();
        i_host.write_reg(RD_LOCAL_TEMP, 8'h33);
        rd_chk(RD_LOCAL_TEMP, 8'h14);
        i_host.write_reg(RD_LOCAL_HIGH, 8'h11);
        rd_chk(RD_LOCAL_HIGH, HIGH_RESET);
        i_host.write_reg(WR_CONV_RATE, 8'h05);
        rd_chk(RD_CONV_RATE, 8'h05);
        `CHK(conv_rate_q, 3'h5);
    endtask
    initial
    begin
        wait_cyc(8);
        rstn = 1'b1;
        t_reset();
        t_average();
        t_limits();
        t_open();
        t_stop();
        t_protect();
        stop_test();
    end
endmodule
